// >>> verilog/dac_serial_load.sv
// Purpose: serial shift and dual holding registers of a two-channel DAC
// Assumes: SCLK is the host's serial clock, may stop between frames;
//          control pins sampled in the CLK domain through two flops
// Notes:   shift register lives on SCLK; each complete word not overwritten crosses
//          to CLK via a handshake and a FIFO; strobes act in CLK domain
// Operation
// R1: shift one bit from serial_in per serial clock rise while enabled
// R2: shift register holds when select high or clock static
// R3: holding register takes shift data on strobe fall, follows while low
// R4: preset strobe low with select high forces both registers to half scale
// R5: preset strobe low with select low forces both registers to zero
// R6: preset strobe rising with load strobes high keeps the preset value
// R7: host sends no serial clock edges while a load strobe is low
// R8: twelve-bit word is sent MSB first, first bit lands in bit 11
// R9: ten-bit word is sent MSB first, first bit lands in bit 9
// R10: strobe A loads only channel A, strobe B only channel B
// R11: chip select does not affect load strobe operation
// R12: preset strobe is asynchronous active low, zero or half scale; the code samples it through two CLK flops and presets on a CLK edge
// R13: power-down low freezes shift and holding registers
// R14: ten-bit half scale sets only the top bit of ten
`timescale 1ns/1ps
`default_nettype none
`include "dac_load_regs.svh"
module dac_serial_load #(
    parameter int DATA_W = `WORD_BITS_12,
    parameter int DEPTH  = `FIFO_DEPTH_WORDS
) (
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    input  wire logic              SCLK,
    input  wire logic              CS_N,
    input  wire logic              SERIAL_IN,
    input  wire logic              LOAD_STROBE_A_N,
    input  wire logic              LOAD_STROBE_B_N,
    input  wire logic              PRESET_STROBE_N,
    input  wire logic              PRESET_SEL,
    input  wire logic              POWER_DOWN_N,
    output logic      [DATA_W-1:0] DAC_A,
    output logic      [DATA_W-1:0] DAC_B,
    output logic                   WORD_OVERRUN
);
    initial begin
        if (DATA_W != `WORD_BITS_12 && DATA_W != `WORD_BITS_10) begin
            $error("dac_serial_load: DATA_W must be 12 or 10");
        end
    end

    localparam int CW = $clog2(DATA_W + 1);

    // preset code for a given select level
    function automatic logic [DATA_W-1:0] preset_code(input logic half);
        logic [DATA_W-1:0] v;
        v = '0;
        v[DATA_W-1] = half; // [R4] [R14]
        return v;
    endfunction

    // link domain: control levels seen at the serial clock
    logic              cs_s1_q;
    logic              cs_s2_q;
    logic              run_s1_q;
    logic              run_s2_q;
    logic [DATA_W-1:0] shift_q;
    logic [CW-1:0]     bits_q;
    logic              word_valid_q;
    logic [DATA_W-1:0] word_q;
    logic              word_ready;
    logic              shift_en;

    // pin levels into SCLK domain; reset from the core reset
    always_ff @(posedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            run_s1_q <= 1'b0;
            run_s2_q <= 1'b0;
        end else begin
            cs_s1_q  <= CS_N;
            cs_s2_q  <= cs_s1_q;
            run_s1_q <= PRESET_STROBE_N && POWER_DOWN_N;
            run_s2_q <= run_s1_q;
        end
    end

    assign shift_en = !cs_s2_q && run_s2_q; // [R1] [R13]

    // the shift register moves only on SCLK rises, so a static clock or
    // a select rise while the clock is low leaves it untouched
    always_ff @(posedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            shift_q <= '0;
        end else if (shift_en) begin // [R2]
            shift_q <= {shift_q[DATA_W-2:0], SERIAL_IN}; // [R1] [R8] [R9]
        end
    end

    // bit counter frames a word once DATA_W bits have arrived
    always_ff @(posedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bits_q <= '0;
        end else if (!shift_en) begin
            bits_q <= '0;
        end else if (bits_q == CW'(DATA_W - 1)) begin
            bits_q <= '0;
        end else begin
            bits_q <= bits_q + 1'b1;
        end
    end

    always_ff @(posedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            word_valid_q <= 1'b0;
            word_q       <= '0;
        end else if (shift_en && bits_q == CW'(DATA_W - 1)) begin
            word_valid_q <= 1'b1;
            word_q       <= {shift_q[DATA_W-2:0], SERIAL_IN}; // [R8] [R9]
        end else if (word_ready) begin
            word_valid_q <= 1'b0;
        end
    end

    // a word still waiting on the crossing when the next one completes is overwritten and flagged
    logic ovr_tgl_q;
    always_ff @(posedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ovr_tgl_q <= 1'b0;
        end else if (shift_en && bits_q == CW'(DATA_W - 1)
                     && word_valid_q && !word_ready) begin
            ovr_tgl_q <= ~ovr_tgl_q;
        end
    end

    // crossing and buffer
    logic              cdc_valid;
    logic              cdc_ready;
    logic [DATA_W-1:0] cdc_data;
    logic              fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_pop;

    word_cdc #(
        .WIDTH(DATA_W)
    ) u_cdc (
        .SRC_CLK  (SCLK),
        .SRC_RST_N(ARST_N),
        .SRC_VALID(word_valid_q),
        .SRC_READY(word_ready),
        .SRC_DATA (word_q),
        .DST_CLK  (CLK),
        .DST_RST_N(ARST_N),
        .DST_VALID(cdc_valid),
        .DST_READY(cdc_ready),
        .DST_DATA (cdc_data)
    );

    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .CLK      (CLK),
        .ARST_N   (ARST_N),
        .IN_VALID (cdc_valid),
        .IN_READY (cdc_ready),
        .IN_DATA  (cdc_data),
        .OUT_VALID(fifo_valid),
        .OUT_READY(fifo_pop),
        .OUT_DATA (fifo_data)
    );

    // core domain: pin synchronisers
    logic [`PIN_W-1:0] pin_s1_q;
    logic [`PIN_W-1:0] pin_s2_q;
    logic [2:0]        ovr_s_q;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_s1_q <= `PIN_IDLE;
            pin_s2_q <= `PIN_IDLE;
            ovr_s_q  <= '0;
        end else begin
            pin_s1_q <= {LOAD_STROBE_A_N, LOAD_STROBE_B_N, PRESET_STROBE_N,
                         POWER_DOWN_N, PRESET_SEL};
            pin_s2_q <= pin_s1_q;
            ovr_s_q  <= {ovr_s_q[1:0], ovr_tgl_q};
        end
    end

    logic strobe_a_n;
    logic strobe_b_n;
    logic preset_n;
    logic pd_n;
    logic half;
    assign strobe_a_n = pin_s2_q[`PIN_LOAD_A];
    assign strobe_b_n = pin_s2_q[`PIN_LOAD_B];
    assign preset_n   = pin_s2_q[`PIN_PRESET];
    assign pd_n       = pin_s2_q[`PIN_POWER];
    assign half       = pin_s2_q[`PIN_SEL];

    // latest complete word; the FIFO drains unless powered down so this tracks the
    // shift register as seen by the strobes, one word behind at most
    logic [DATA_W-1:0] latest_q;
    assign fifo_pop = fifo_valid && pd_n;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            latest_q <= '0;
        end else if (fifo_pop) begin
            latest_q <= fifo_data;
        end
    end

    // preset level is an argument so the assigns also wake on its change
    function automatic dac_load_pkg::hold_mode_t mode_of(
        input logic pre_n,
        input logic ld_n
    );
        if (!pre_n) begin
            return dac_load_pkg::HOLD_PRESET; // [R12]
        end else if (!ld_n) begin
            return dac_load_pkg::HOLD_TRANSPARENT; // [R3] [R11]
        end
        return dac_load_pkg::HOLD_LATCHED;
    endfunction

    dac_load_pkg::hold_mode_t mode_a;
    dac_load_pkg::hold_mode_t mode_b;
    logic [DATA_W-1:0]        pre_val;
    assign mode_a  = mode_of(preset_n, strobe_a_n); // [R10]
    assign mode_b  = mode_of(preset_n, strobe_b_n); // [R10]
    assign pre_val = preset_code(half); // [R4] [R5] [R14]

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DAC_A <= '0;
        end else if (pd_n) begin // [R13]
            case (mode_a)
                dac_load_pkg::HOLD_PRESET:      DAC_A <= pre_val; // [R4] [R5]
                dac_load_pkg::HOLD_TRANSPARENT: DAC_A <= latest_q; // [R3]
                dac_load_pkg::HOLD_LATCHED:     DAC_A <= DAC_A; // [R6]
                default:                        DAC_A <= DAC_A;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DAC_B <= '0;
        end else if (pd_n) begin // [R13]
            case (mode_b)
                dac_load_pkg::HOLD_PRESET:      DAC_B <= pre_val; // [R4] [R5]
                dac_load_pkg::HOLD_TRANSPARENT: DAC_B <= latest_q; // [R3]
                dac_load_pkg::HOLD_LATCHED:     DAC_B <= DAC_B; // [R6]
                default:                        DAC_B <= DAC_B;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WORD_OVERRUN <= 1'b0;
        end else if (ovr_s_q[2] != ovr_s_q[1]) begin
            WORD_OVERRUN <= 1'b1;
        end
    end

    preset_value_a: assert property ( // [R4]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && !preset_n |=> DAC_A == preset_code($past(half)))
        else $error("channel A not preset");
    zero_code_a: assert property ( // [R5]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && !preset_n && !half |=> DAC_A == '0 && DAC_B == '0)
        else $error("zero preset code wrong");
    preset_keep_a: assert property ( // [R6]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && $rose(preset_n) && strobe_a_n && strobe_b_n
        |=> $stable(DAC_A) && $stable(DAC_B))
        else $error("preset value not kept");
    freeze_pd_a: assert property ( // [R13]
        @(posedge CLK) disable iff (!ARST_N)
        !pd_n |=> $stable(DAC_A) && $stable(DAC_B))
        else $error("holding register moved in power down");
    load_follow_a: assert property ( // [R3]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && preset_n && !strobe_a_n |=> DAC_A == $past(latest_q))
        else $error("channel A not transparent");
    follow_b_a: assert property ( // [R3]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && preset_n && !strobe_b_n |=> DAC_B == $past(latest_q))
        else $error("channel B not transparent");
    latch_hold_a: assert property ( // [R10]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && preset_n && strobe_b_n |=> $stable(DAC_B))
        else $error("channel B moved without its strobe");
    latch_keep_a: assert property ( // [R10]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && preset_n && strobe_a_n |=> $stable(DAC_A))
        else $error("channel A moved without its strobe");
    shift_hold_a: assert property ( // [R2]
        @(posedge SCLK) disable iff (!ARST_N)
        !shift_en |=> $stable(shift_q))
        else $error("shift register moved while disabled");
    shift_in_a: assert property ( // [R1]
        @(posedge SCLK) disable iff (!ARST_N)
        shift_en |=> shift_q[0] == $past(SERIAL_IN))
        else $error("serial bit not shifted in");
    half_code_a: assert property ( // [R14]
        @(posedge CLK) disable iff (!ARST_N)
        pd_n && !preset_n && half
        |=> DAC_B[DATA_W-1] && DAC_B[DATA_W-2:0] == '0)
        else $error("half scale code wrong");
endmodule
`default_nettype wire

// >>> verilog/dac_load_regs.svh
// Purpose: named constants for the dual converter serial load logic
// Assumes: holding registers are DATA_W bits wide, MSB at DATA_W-1
// Notes:   timing figures are for the 3 V grade
`ifndef DAC_LOAD_REGS_SVH
`define DAC_LOAD_REGS_SVH

`define WORD_BITS_12     12
`define WORD_BITS_10     10
`define FIFO_DEPTH_WORDS 32
`define CLK_PERIOD_PS    40000
`define LOAD_WIDTH_NS    30
`define CLEAR_WIDTH_NS   15
`define LOAD_WIDTH_CYC \
    ((`LOAD_WIDTH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CLEAR_WIDTH_CYC \
    ((`CLEAR_WIDTH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PIN_W            5
`define PIN_IDLE         5'h1f
`define PIN_LOAD_A       4
`define PIN_LOAD_B       3
`define PIN_PRESET       2
`define PIN_POWER        1
`define PIN_SEL          0

`endif

// >>> verilog/dac_load_pkg.sv
// Purpose: shared types for the serial load logic
// Assumes: nothing
// Notes:   constants live in dac_load_regs.svh
package dac_load_pkg;
    typedef enum logic [1:0] {
        HOLD_LATCHED,
        HOLD_TRANSPARENT,
        HOLD_PRESET
    } hold_mode_t;
endpackage

// >>> verilog/word_fifo.sv
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, active-low async reset
// Notes:   full and empty are exact; no write while full
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input  wire logic             CLK,
    input  wire logic             ARST_N,
    input  wire logic             IN_VALID,
    output logic                  IN_READY,
    input  wire logic [WIDTH-1:0] IN_DATA,
    output logic                  OUT_VALID,
    input  wire logic             OUT_READY,
    output logic      [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("word_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign IN_READY  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign OUT_VALID = wr_q != rd_q;
    assign OUT_DATA  = mem_q[rd_q[AW-1:0]];
    assign push      = IN_VALID && IN_READY;
    assign pop       = OUT_VALID && OUT_READY;

    always_ff @(posedge CLK) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end

    fifo_count_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (wr_q - rd_q) <= (AW+1)'(DEPTH))
        else $error("fifo occupancy beyond depth");
    fifo_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        !IN_READY && !pop |=> !IN_READY)
        else $error("fifo full dropped without a pop");
endmodule
`default_nettype wire

// >>> verilog/word_cdc.sv
// Purpose: toggle handshake carrying one word between clock domains
// Assumes: source holds data stable until the busy flag drops
// Notes:   one word in flight; throughput traded for simplicity
`timescale 1ns/1ps
`default_nettype none
module word_cdc #(
    parameter int WIDTH = 12
) (
    input  wire logic             SRC_CLK,
    input  wire logic             SRC_RST_N,
    input  wire logic             SRC_VALID,
    output logic                  SRC_READY,
    input  wire logic [WIDTH-1:0] SRC_DATA,
    input  wire logic             DST_CLK,
    input  wire logic             DST_RST_N,
    output logic                  DST_VALID,
    input  wire logic             DST_READY,
    output logic      [WIDTH-1:0] DST_DATA
);
    initial begin
        if (WIDTH < 1) begin
            $error("word_cdc: WIDTH must be positive");
        end
    end

    logic             req_q;
    logic [WIDTH-1:0] hold_q;
    logic             ack_s1_q;
    logic             ack_s2_q;
    logic             req_s1_q;
    logic             req_s2_q;
    logic             ack_q;

    assign SRC_READY = req_q == ack_s2_q;
    assign DST_VALID = req_s2_q != ack_q;
    assign DST_DATA  = hold_q;

    always_ff @(posedge SRC_CLK or negedge SRC_RST_N) begin
        if (!SRC_RST_N) begin
            req_q  <= 1'b0;
            hold_q <= '0;
        end else if (SRC_VALID && SRC_READY) begin
            req_q  <= ~req_q;
            hold_q <= SRC_DATA;
        end
    end

    always_ff @(posedge SRC_CLK or negedge SRC_RST_N) begin
        if (!SRC_RST_N) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    always_ff @(posedge DST_CLK or negedge DST_RST_N) begin
        if (!DST_RST_N) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
        end
    end

    always_ff @(posedge DST_CLK or negedge DST_RST_N) begin
        if (!DST_RST_N) begin
            ack_q <= 1'b0;
        end else if (DST_VALID && DST_READY) begin
            ack_q <= ~ack_q;
        end
    end
endmodule
`default_nettype wire

// >>> sim/host_serial_model.sv
// Purpose: host side of the serial link, shifts words MSB first
// Assumes: 15 ns serial clock, stopped between send calls
// Notes:   data line shows the inverse of the last bit when idle
`timescale 1ns/1ps
`default_nettype none
module host_serial_model #(
    parameter int W = 12
) (
    output logic SCLK,
    output logic CS_N,
    output logic SERIAL_IN
);
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SERIAL_IN = 1'b0;
    end

    task automatic pulse(input int n);
        repeat (n) begin
            #7.5 SCLK = 1'b1;
            #7.5 SCLK = 1'b0;
        end
    endtask

    // sel low sends the frame with the chip deselected, to be ignored
    task automatic send(input logic [W-1:0] w, input logic sel);
        int i;
        CS_N = ~sel;
        pulse(2);
        for (i = W - 1; i >= 0; i--) begin
            SERIAL_IN = w[i];
            pulse(1);
        end
        SERIAL_IN = ~w[0];
        CS_N = 1'b1;
        // clock kept running so the completed word enters the crossing and the select rise is seen
        pulse(6);
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the dual converter load logic
// Assumes: 12-bit and 10-bit instances share strobes and presets
// Notes: strobes stay high while any host frame runs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        la_n = 1'b1;
    logic        lb_n = 1'b1;
    logic        pre_n = 1'b1;
    logic        pre_sel = 1'b0;
    logic        pd_n = 1'b1;
    wire         sclk12, cs12, sd12, sclk10, cs10, sd10;
    wire         ovr12, ovr10;
    logic [11:0] a12, b12;
    logic [9:0]  a10, b10;
    int          failures = 0;
    int          comparisons = 0;

    always #20 clk = ~clk;

    host_serial_model #(.W(12)) host12 (
        .SCLK(sclk12), .CS_N(cs12), .SERIAL_IN(sd12));
    host_serial_model #(.W(10)) host10 (
        .SCLK(sclk10), .CS_N(cs10), .SERIAL_IN(sd10));

    dac_serial_load #(.DATA_W(12)) dut (
        .CLK(clk), .ARST_N(arst_n), .SCLK(sclk12), .CS_N(cs12),
        .SERIAL_IN(sd12), .LOAD_STROBE_A_N(la_n), .LOAD_STROBE_B_N(lb_n),
        .PRESET_STROBE_N(pre_n), .PRESET_SEL(pre_sel),
        .POWER_DOWN_N(pd_n), .DAC_A(a12), .DAC_B(b12),
        .WORD_OVERRUN(ovr12));
    dac_serial_load #(.DATA_W(10)) dut10 (
        .CLK(clk), .ARST_N(arst_n), .SCLK(sclk10), .CS_N(cs10),
        .SERIAL_IN(sd10), .LOAD_STROBE_A_N(la_n), .LOAD_STROBE_B_N(lb_n),
        .PRESET_STROBE_N(pre_n), .PRESET_SEL(pre_sel),
        .POWER_DOWN_N(pd_n), .DAC_A(a10), .DAC_B(b10),
        .WORD_OVERRUN(ovr10));

    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // strobes pulse only between host frames
    task automatic strobe(input logic a, input logic b);
        @(posedge clk);
        la_n <= ~a;
        lb_n <= ~b;
        cyc(4);
        la_n <= 1'b1;
        lb_n <= 1'b1;
    endtask

    // bounded wait until channel A of the 12-bit part shows a value
    task automatic wait_a(input logic [11:0] exp);
        int i;
        for (i = 0; i < 60 && a12 !== exp; i++)
            @(negedge clk);
        if (a12 !== exp) begin
            check("wait channel a", a12, exp);
            complete_run();
        end else begin
            cyc(10);
        end
    endtask

    task automatic t_reset();
        check("a12 reset", a12, 12'h000);
        check("b12 reset", b12, 12'h000);
        check("a10 reset", {2'h0, a10}, 12'h000);
        check("b10 reset", {2'h0, b10}, 12'h000);
    endtask

    task automatic t_load_a();
        host12.send(12'ha5c, 1'b1);
        host10.send(10'h2b7, 1'b1);
        strobe(1'b1, 1'b0);
        wait_a(12'ha5c);
        check("a12 load", a12, 12'ha5c);
        check("a10 load", {2'h0, a10}, 12'h2b7);
        check("b12 untouched", b12, 12'h000);
        check("b10 untouched", {2'h0, b10}, 12'h000);
    endtask

    // chip select stays high while strobe b acts
    task automatic t_load_b();
        int i;
        host12.send(12'h3c1, 1'b1);
        host10.send(10'h0e4, 1'b1);
        strobe(1'b0, 1'b1);
        for (i = 0; i < 60 && b12 !== 12'h3c1; i++)
            @(negedge clk);
        if (b12 !== 12'h3c1) begin
            check("wait channel b", b12, 12'h3c1);
            complete_run();
        end else begin
            cyc(10);
        end
        check("b12 load", b12, 12'h3c1);
        check("b10 load", {2'h0, b10}, 12'h0e4);
        check("a12 kept", a12, 12'ha5c);
    endtask

    // a deselected frame must not replace the last complete word
    task automatic t_hold();
        host12.send(12'h111, 1'b1);
        host12.send(12'hfff, 1'b0);
        cyc(20);
        check("a12 latched", a12, 12'ha5c);
        check("b12 latched", b12, 12'h3c1);
        strobe(1'b1, 1'b1);
        wait_a(12'h111);
        check("a12 after deselect", a12, 12'h111);
        check("b12 after deselect", b12, 12'h111);
        check("a10 both", {2'h0, a10}, 12'h0e4);
    endtask

    task automatic t_preset(input logic sel, input logic [11:0] e12,
                            input logic [11:0] e10);
        @(posedge clk);
        pre_sel <= sel;
        pre_n <= 1'b0;
        wait_a(e12);
        check("a12 preset", a12, e12);
        check("b12 preset", b12, e12);
        check("a10 preset", {2'h0, a10}, e10);
        check("b10 preset", {2'h0, b10}, e10);
        pre_n <= 1'b1;
        cyc(12);
        check("a12 after preset", a12, e12);
        check("b10 after preset", {2'h0, b10}, e10);
    endtask

    // frozen parts ignore both presets and serial frames
    task automatic t_power_down();
        strobe(1'b1, 1'b1);
        wait_a(12'h111);
        pd_n <= 1'b0;
        cyc(6);
        pre_sel <= 1'b1;
        pre_n <= 1'b0;
        cyc(10);
        pre_n <= 1'b1;
        cyc(6);
        // a frame sent while frozen must never reach a register
        host12.send(12'h7e7, 1'b1);
        @(posedge clk);
        check("a12 frozen", a12, 12'h111);
        check("a10 frozen", {2'h0, a10}, 12'h0e4);
        pd_n <= 1'b1;
        cyc(10);
        check("a12 after wake", a12, 12'h111);
        strobe(1'b1, 1'b0);
        cyc(8);
        check("a12 frozen frame", a12, 12'h111);
        check("overrun12", {11'h000, ovr12}, 12'h000);
        check("overrun10", {11'h000, ovr10}, 12'h000);
    endtask

    initial begin
        fork
            cyc(16);
            begin
                host12.pulse(4);
                host10.pulse(4);
            end
        join
        arst_n <= 1'b1;
        cyc(4);
        t_reset();
        t_load_a();
        t_load_b();
        t_hold();
        t_preset(1'b1, 12'h800, 12'h200);
        t_preset(1'b0, 12'h000, 12'h000);
        t_power_down();
        complete_run();
    end
endmodule
`default_nettype wire
